// ==== design/uart_line_status_irq_id.sv ====
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
module uart_line_status_irq_id
    import uart_lsr_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_nrst,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // Receiver side
    input  wire logic              i_baud_tick,
    input  wire logic              i_serial_in,
    input  wire logic              i_rx_valid,
    input  wire logic [7:0]        i_rx_char,
    input  wire logic              i_rx_parity_error,
    input  wire logic              i_rx_framing_error,
    // Transmitter side
    output logic                   o_tx_load,
    output logic      [7:0]        o_tx_char,
    input  wire logic              i_tx_shift_done,
    // Modem inputs, active low pins
    input  wire logic              i_cts_n,
    input  wire logic              i_dsr_n,
    input  wire logic              i_ri_n,
    input  wire logic              i_dcd_n,
    // Interrupts
    output logic                   o_intrpt,
    output logic                   o_event_irq
);
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Register state.
    logic [7:0] rx_buf;
    logic       data_ready;
    logic [3:0] lsr_err;
    logic [7:0] tx_hold_reg;
    logic       tx_hold_full;
    logic       tx_shift_full;
    logic       tx_hold_empty_flag;
    logic       hold_irq;
    logic [3:0] ier;
    logic [3:0] lcr;
    logic [3:0] modem_prev;
    logic [3:0] msr_delta;
    logic [3:0] evt_status;
    logic [3:0] evt_mask;
    logic       line_break;

    // Bus decode.
    wire setup  = i_psel & ~i_penable;
    wire done   = i_psel & i_penable & o_pready;
    wire wr     = done & i_pwrite;
    wire rd     = done & ~i_pwrite;
    wire at_dat = i_paddr == OFF_DATA;
    wire at_ier = i_paddr == OFF_IER;
    wire at_cid = i_paddr == OFF_CAUSE;
    wire at_lcr = i_paddr == OFF_LCR;
    wire at_lsr = i_paddr == OFF_LSR;
    wire at_msr = i_paddr == OFF_MSR;
    wire at_evs = i_paddr == OFF_EVT_STATUS;
    wire at_evm = i_paddr == OFF_EVT_MASK;
    wire hit    = at_dat | at_ier | at_cid | at_lcr | at_lsr | at_msr | at_evs | at_evm;

    wire hld_wr = wr & at_dat;
    wire rbr_rd = rd & at_dat;
    wire lsr_rd = rd & at_lsr;
    wire msr_rd = rd & at_msr;
    wire cid_rd = rd & at_cid;

    // Pending sources, gated by the enables.
    wire ls_pend   = ier[IER_LS] & (|lsr_err);
    wire rda_pend  = ier[IER_RDA] & data_ready;
    wire hold_pend = ier[IER_HOLD] & hold_irq;
    wire ms_pend   = ier[IER_MS] & (|msr_delta);
    wire any_pend  = ls_pend | rda_pend | hold_pend | ms_pend;

    // Priority encoder for the cause code.
    wire [2:0] cause_code = ls_pend   ? CODE_LS   :
                            rda_pend  ? CODE_RDA  :
                            hold_pend ? CODE_HOLD :
                            ms_pend   ? CODE_MS   : CODE_NONE;

    wire       tx_all_empty_flag = ~tx_hold_full & ~tx_shift_full;
    wire [7:0] lsr  = {1'b0, tx_all_empty_flag, tx_hold_empty_flag, lsr_err, data_ready};
    wire [3:0] pins = {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
    wire [7:0] msr  = {~pins, msr_delta};

    wire [7:0] rd_mux = at_dat ? rx_buf :
                        at_ier ? {4'h0, ier} :
                        at_cid ? {5'h00, cause_code} :
                        at_lcr ? {4'h0, lcr} :
                        at_lsr ? lsr :
                        at_msr ? msr :
                        at_evs ? {4'h0, evt_status} :
                        at_evm ? {4'h0, evt_mask} : 8'h00;

    // Read data are captured at the setup cycle and held through the access, so the
    // cause code seen by the host cannot change while it is addressed.
    wire [31:0] next_prdata = (setup && !i_pwrite) ? {24'h00_0000, rd_mux} : o_prdata;
    wire        next_pready = setup;
    wire        next_pslverr = setup & ~hit;

    // Read-to-clear drops only the bits the host actually saw, so a flag raised
    // between capture and completion survives to the next read.
    wire [3:0] err_clr = lsr_rd ? o_prdata[LSR_BREAK:LSR_OE] : 4'h0;
    wire [3:0] ms_clr  = msr_rd ? o_prdata[3:0] : 4'h0;

    // Error and modem events.
    wire       overrun = i_rx_valid & data_ready & ~rbr_rd;
    wire [3:0] err_set = {line_break, i_rx_valid & i_rx_framing_error,
                          i_rx_valid & i_rx_parity_error, overrun};
    wire [3:0] ms_chg  = modem_prev ^ pins;
    wire [3:0] ms_set  = {ms_chg[3], ~modem_prev[2] & i_ri_n, ms_chg[1:0]};

    // Transmit path; the move waits one cycle when the host writes at the same time.
    wire move    = tx_hold_full & ~tx_shift_full & ~hld_wr;
    wire hld_clr = hld_wr | (cid_rd && o_prdata[2:0] == CODE_HOLD);

    wire [3:0] evt_set = {|ms_set, |err_set, move, i_rx_valid};
    wire [3:0] evt_w1c = (wr && at_evs) ? i_pwdata[3:0] : 4'h0;

    // Break threshold in 16x ticks from the current character format.
    wire [3:0] char_bits = CHAR_BITS_MIN + {2'b00, lcr[1:0]}
                         + {3'b000, lcr[LCR_PEN]} + {3'b000, lcr[LCR_STOP2]};
    wire [BREAK_CNT_W-1:0] char_ticks = BREAK_CNT_W'(char_bits) << OVERSAMPLE_SHIFT;

    uart_break_detect #(
        .CNT_W        (BREAK_CNT_W)
    ) u_break (
        .i_clock      (i_clock),
        .i_nrst       (rst_n),
        .i_tick       (i_baud_tick),
        .i_line       (i_serial_in),
        .i_char_ticks (char_ticks),
        .o_break      (line_break)
    );

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            ier       <= IER_RESET;
            lcr       <= LCR_RESET;
            evt_mask  <= EVT_RESET;
        end else begin
            o_prdata  <= next_prdata;
            o_pready  <= next_pready;
            o_pslverr <= next_pslverr;
            // Line status and modem status ignore writes; that path is test only.
            if (wr && at_ier) begin
                ier <= i_pwdata[3:0];
            end
            if (wr && at_lcr) begin
                lcr <= i_pwdata[3:0];
            end
            if (wr && at_evm) begin
                evt_mask <= i_pwdata[3:0];
            end
        end
    end

    // Receive buffer and error flags; a new event wins over a clear.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf     <= 8'h00;
            data_ready <= 1'b0;
            lsr_err    <= 4'h0;
        end else begin
            if (i_rx_valid) begin
                rx_buf <= i_rx_char;
            end
            data_ready <= i_rx_valid | (data_ready & ~rbr_rd);
            lsr_err    <= (lsr_err & ~err_clr) | err_set;
        end
    end

    // Transmit holding and shift occupancy.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_hold_reg        <= 8'h00;
            tx_hold_full       <= 1'b0;
            tx_shift_full      <= 1'b0;
            tx_hold_empty_flag <= 1'b1;
            hold_irq           <= 1'b0;
            o_tx_load          <= 1'b0;
            o_tx_char          <= 8'h00;
        end else begin
            if (hld_wr) begin
                tx_hold_reg <= i_pwdata[7:0];
            end
            tx_hold_full       <= hld_wr | (tx_hold_full & ~move);
            tx_shift_full      <= move | (tx_shift_full & ~i_tx_shift_done);
            tx_hold_empty_flag <= move | (tx_hold_empty_flag & ~hld_wr);
            hold_irq           <= move | (hold_irq & ~hld_clr);
            o_tx_load          <= move;
            if (move) begin
                o_tx_char <= tx_hold_reg;
            end
        end
    end

    // Modem deltas and the event interrupt block.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            modem_prev  <= MODEM_IDLE;
            msr_delta   <= 4'h0;
            evt_status  <= EVT_RESET;
            o_intrpt    <= 1'b0;
            o_event_irq <= 1'b0;
        end else begin
            modem_prev  <= pins;
            msr_delta   <= (msr_delta & ~ms_clr) | ms_set;
            evt_status  <= (evt_status & ~evt_w1c) | evt_set;
            o_intrpt    <= any_pend;
            o_event_irq <= |(evt_status & evt_mask);
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n);

    sequence s_setup;
        i_psel && !i_penable;
    endsequence

    sequence s_lsr_read;
        i_psel && !i_penable && !i_pwrite && at_lsr ##1 o_pready;
    endsequence

    a_apb_one_wait: assert property (s_setup |=> o_pready)
        else $error("no ready in the cycle after setup");

    a_break_to_flag: assert property (line_break |=> lsr_err[3])
        else $error("break pulse did not set the break flag");

    a_lsr_read_clears: assert property (s_lsr_read ##0 (i_penable && o_prdata[LSR_BREAK]
            && !line_break) |=> !lsr_err[3])
        else $error("line status read left break flag set");

    a_line_err_irq: assert property ((|err_set && ier[IER_LS] && !(wr && at_ier))
            |=> ##1 o_intrpt)
        else $error("line error did not raise the interrupt");

    a_hold_write_clears: assert property (hld_wr |=> !tx_hold_empty_flag && !hold_irq)
        else $error("hold write did not clear hold-empty");

    a_move_sets_empty: assert property (move |=> tx_hold_empty_flag && hold_irq
            && o_tx_load)
        else $error("transfer to shift did not set hold-empty");

    a_all_empty_busy: assert property (hld_wr |=> !lsr[LSR_ALL_EMPTY])
        else $error("all-empty high while hold full");

    a_lsr_bit7_zero: assert property (s_lsr_read |-> !o_prdata[7])
        else $error("line status bit 7 read as one");

    a_code_priority: assert property (s_setup ##0 (at_cid && !i_pwrite && ls_pend)
            |=> o_prdata[2:0] == CODE_LS)
        else $error("line status not reported first");

    a_hold_gated: assert property (s_setup ##0 (at_cid && !i_pwrite && !ier[IER_HOLD])
            |=> o_prdata[2:0] != CODE_HOLD)
        else $error("disabled hold-empty reported as cause");

    // The capture edge itself changes the read data, so stability is judged one cycle on.
    a_code_frozen: assert property (s_setup ##0 at_cid ##1 (i_penable && at_cid)
            |=> $stable(o_prdata))
        else $error("cause code changed while addressed");

    a_cause_read_clear: assert property ((cid_rd && o_prdata[2:0] == CODE_HOLD && !move)
            |=> !hold_irq)
        else $error("cause read did not clear hold-empty irq");

    a_msr_read_clear: assert property ((msr_rd && ms_set == 4'h0) |=>
            (msr_delta & $past(o_prdata[3:0])) == 4'h0)
        else $error("modem read did not clear deltas");

    a_intrpt_level: assert property (any_pend[*2] |=> o_intrpt)
        else $error("interrupt low with an enabled source");
endmodule

// ==== design/uart_lsr_pkg.sv ====
package uart_lsr_pkg;

    // APB register map, byte addresses of aligned 32-bit words.
    localparam int        ADDR_W          = 8;
    localparam logic [7:0] OFF_DATA       = 8'h00;
    localparam logic [7:0] OFF_IER        = 8'h04;
    localparam logic [7:0] OFF_CAUSE      = 8'h08;
    localparam logic [7:0] OFF_LCR        = 8'h0C;
    localparam logic [7:0] OFF_LSR        = 8'h14;
    localparam logic [7:0] OFF_MSR        = 8'h18;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h20;
    localparam logic [7:0] OFF_EVT_MASK   = 8'h24;

    // Line status bit positions.
    localparam int LSR_DR         = 0;
    localparam int LSR_OE         = 1;
    localparam int LSR_BREAK      = 4;
    localparam int LSR_HOLD_EMPTY = 5;
    localparam int LSR_ALL_EMPTY  = 6;

    // Interrupt enable bit positions.
    localparam int IER_RDA  = 0;
    localparam int IER_HOLD = 1;
    localparam int IER_LS   = 2;
    localparam int IER_MS   = 3;

    // Pending cause codes, bits 2..0.
    localparam logic [2:0] CODE_NONE = 3'h1;
    localparam logic [2:0] CODE_LS   = 3'h6;
    localparam logic [2:0] CODE_RDA  = 3'h4;
    localparam logic [2:0] CODE_HOLD = 3'h2;
    localparam logic [2:0] CODE_MS   = 3'h0;

    // Line control: [1:0] data bits minus five, [2] two stop bits, [3] parity.
    localparam int         LCR_STOP2     = 2;
    localparam int         LCR_PEN       = 3;
    localparam logic [3:0] CHAR_BITS_MIN = 4'h7;

    // Reset values.
    localparam logic [3:0] IER_RESET   = 4'h0;
    localparam logic [3:0] LCR_RESET   = 4'h3;
    localparam logic [3:0] MODEM_IDLE  = 4'hF;
    localparam logic [3:0] EVT_RESET   = 4'h0;

    // Break timing in 16x sampling ticks.
    localparam int OVERSAMPLE_SHIFT = 4;
    localparam int BREAK_CNT_W      = 9;

endpackage

// ==== design/uart_break_detect.sv ====
`timescale 1ns/10ps
module uart_break_detect
    import uart_lsr_pkg::*;
#(
    parameter int CNT_W = BREAK_CNT_W
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_nrst,
    // Serial line and timing
    input  wire logic             i_tick,
    input  wire logic             i_line,
    input  wire logic [CNT_W-1:0] i_char_ticks,
    // Result
    output logic                  o_break
);
    logic [CNT_W-1:0] count;
    logic             fired;
    wire              over = count > i_char_ticks;

    // The count saturates one tick past a character time, so a long break fires once.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            count   <= '0;
            fired   <= 1'b0;
            o_break <= 1'b0;
        end else begin
            if (i_line) begin
                count <= '0;
            end else if (i_tick && !over) begin
                count <= count + 1'b1;
            end
            o_break <= over & ~fired & ~i_line;
            fired   <= ~i_line & (fired | over);
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    a_break_single_pulse: assert property (o_break |=> !o_break)
        else $error("break pulse lasted more than one cycle");
endmodule

// ==== testbench/tx_far_end.sv ====
`timescale 1ns/10ps
module tx_far_end #(
    parameter int SHIFT_CYCLES = 20
) (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_nrst,
    // Shift register handshake
    input  wire logic i_tx_load,
    output logic      o_tx_shift_done
);
    // A slow line keeps the shift register busy so that the hold register fills behind it.
    int count;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            count <= 0;
            o_tx_shift_done <= 1'b0;
        end else begin
            o_tx_shift_done <= (count == 1);
            if (i_tx_load) begin
                count <= SHIFT_CYCLES;
            end else if (count != 0) begin
                count <= count - 1;
            end
        end
    end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import uart_lsr_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_psel = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite = 1'b0;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        i_rx_valid = 1'b0;
    logic [7:0]  i_rx_char = 8'h00;
    logic        i_rx_perr = 1'b0;
    logic        i_rx_ferr = 1'b0;
    logic        i_serial_in = 1'b1;
    logic        baud_tick = 1'b0;
    logic        i_cts_n = 1'b1;
    logic        o_tx_load;
    logic [7:0]  o_tx_char;
    logic        shift_done;
    logic        o_intrpt;
    logic        o_event_irq;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          n_checks = 0;

    always #2 i_clock = ~i_clock;

    // The 16x sample tick comes every second clock, as a divisor of two would give it.
    always @(posedge i_clock) baud_tick <= ~baud_tick;

    uart_line_status_irq_id dut (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_baud_tick(baud_tick),
        .i_serial_in(i_serial_in), .i_rx_valid(i_rx_valid), .i_rx_char(i_rx_char),
        .i_rx_parity_error(i_rx_perr), .i_rx_framing_error(i_rx_ferr),
        .o_tx_load(o_tx_load), .o_tx_char(o_tx_char), .i_tx_shift_done(shift_done),
        .i_cts_n(i_cts_n), .i_dsr_n(1'b1), .i_ri_n(1'b1), .i_dcd_n(1'b1),
        .o_intrpt(o_intrpt), .o_event_irq(o_event_irq));

    tx_far_end #(.SHIFT_CYCLES(20)) far (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_tx_load(o_tx_load),
        .o_tx_shift_done(shift_done));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= addr;
        i_pwdata <= wdata;
        @(posedge i_clock);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic rx(input logic [7:0] c, input logic pe, input logic fe);
        @(posedge i_clock);
        i_rx_valid <= 1'b1;
        i_rx_char <= c;
        i_rx_perr <= pe;
        i_rx_ferr <= fe;
        @(posedge i_clock);
        i_rx_valid <= 1'b0;
        i_rx_perr <= 1'b0;
        i_rx_ferr <= 1'b0;
    endtask

    task automatic irq_is(input logic exp);
        repeat (2) @(posedge i_clock);
        check({31'h0, o_intrpt}, {31'h0, exp});
    endtask

    initial begin
        #40000;
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge i_clock);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clock);
        rdchk(OFF_CAUSE, 32'h0000_0001);
        rdchk(OFF_LSR, 32'h0000_0060);
        apb(1'b1, OFF_LSR, 32'h0000_00FF);
        rdchk(OFF_LSR, 32'h0000_0060);
        rdchk(8'h3C, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        $display("test reset and map done");
        apb(1'b1, OFF_DATA, 32'h0000_0011);
        repeat (40) @(posedge i_clock);
        irq_is(1'b0);
        apb(1'b1, OFF_IER, 32'h0000_0002);
        apb(1'b1, OFF_DATA, 32'h0000_00A5);
        apb(1'b1, OFF_DATA, 32'h0000_005A);
        rdchk(OFF_LSR, 32'h0000_0000);
        irq_is(1'b0);
        repeat (100) begin
            if (o_intrpt !== 1'b1) @(posedge i_clock);
        end
        irq_is(1'b1);
        check({24'h0, o_tx_char}, 32'h0000_005A);
        rdchk(OFF_CAUSE, 32'h0000_0002);
        rdchk(OFF_CAUSE, 32'h0000_0001);
        irq_is(1'b0);
        repeat (40) @(posedge i_clock);
        rdchk(OFF_LSR, 32'h0000_0060);
        $display("test transmit done");
        apb(1'b1, OFF_IER, 32'h0000_0005);
        apb(1'b1, OFF_EVT_STATUS, 32'h0000_000F);
        apb(1'b1, OFF_EVT_MASK, 32'h0000_0001);
        rx(8'h31, 1'b0, 1'b0);
        rdchk(OFF_CAUSE, 32'h0000_0004);
        check({31'h0, o_event_irq}, 32'h0000_0001);
        apb(1'b1, OFF_EVT_STATUS, 32'h0000_0001);
        repeat (2) @(posedge i_clock);
        check({31'h0, o_event_irq}, 32'h0000_0000);
        rx(8'h32, 1'b1, 1'b0);
        rdchk(OFF_CAUSE, 32'h0000_0006);
        rdchk(OFF_LSR, 32'h0000_0067);
        rdchk(OFF_CAUSE, 32'h0000_0004);
        rdchk(OFF_DATA, 32'h0000_0032);
        rdchk(OFF_CAUSE, 32'h0000_0001);
        rx(8'h33, 1'b0, 1'b1);
        rdchk(OFF_LSR, 32'h0000_0069);
        rdchk(OFF_DATA, 32'h0000_0033);
        irq_is(1'b0);
        $display("test receive done");
        i_serial_in <= 1'b0;
        repeat (300) @(posedge i_clock);
        rdchk(OFF_LSR, 32'h0000_0060);
        repeat (40) @(posedge i_clock);
        rdchk(OFF_CAUSE, 32'h0000_0006);
        rdchk(OFF_LSR, 32'h0000_0070);
        rdchk(OFF_LSR, 32'h0000_0060);
        i_serial_in <= 1'b1;
        // Five data bits with parity make an eight-bit character, a shorter break.
        apb(1'b1, OFF_LCR, 32'h0000_0008);
        rdchk(OFF_LCR, 32'h0000_0008);
        i_serial_in <= 1'b0;
        repeat (230) @(posedge i_clock);
        rdchk(OFF_LSR, 32'h0000_0060);
        repeat (40) @(posedge i_clock);
        rdchk(OFF_LSR, 32'h0000_0070);
        i_serial_in <= 1'b1;
        $display("test break done");
        apb(1'b1, OFF_IER, 32'h0000_0008);
        i_cts_n <= 1'b0;
        repeat (4) @(posedge i_clock);
        rdchk(OFF_CAUSE, 32'h0000_0000);
        rdchk(OFF_MSR, 32'h0000_0011);
        rdchk(OFF_CAUSE, 32'h0000_0001);
        $display("test modem done");
        end_sim();
    end
endmodule
